// ===== pkg/cepc_pkg.sv
package cepc_pkg;
  localparam int unsigned NUM_LEVELS = 16;
  localparam int unsigned LEVEL_W = 4;
  localparam int unsigned NUM_PERIPH = 32;
  localparam int unsigned PERIPH_IDX_W = 5;
  localparam int unsigned ASSIGN_W = 4;
  localparam int unsigned ADDR_W = 32;
  // fixed priority numbers, 0 highest
  localparam logic [3:0] PRIO_EMU = 4'h0;
  localparam logic [3:0] PRIO_RESET = 4'h1;
  localparam logic [3:0] PRIO_NMI = 4'h2;
  localparam logic [3:0] PRIO_EXC = 4'h3;
  localparam logic [3:0] PRIO_RSVD = 4'h4;
  localparam logic [3:0] PRIO_HWERR = 4'h5;
  localparam logic [3:0] PRIO_TIMER = 4'h6;
  localparam logic [3:0] PRIO_GEN_FIRST = 4'h7;
  localparam logic [3:0] PRIO_GEN_LAST = 4'hf;
  localparam logic [3:0] PRIO_SW_FIRST = 4'he;
  // reset values
  localparam logic [15:0] PEND_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [31:0] RETADDR_RESET = 32'h0000_0000;
  // default router map: 4-bit codes, 0 means general level 7
  localparam logic [127:0] ROUTE_DEFAULT =
      128'h4444_4433_3333_2222_1100_0000_0000_0000;
  // dedicated levels that cannot be masked
  localparam logic [15:0] UNMASKABLE = 16'h0007;
  typedef enum logic [1:0] {cepc_idle, cepc_save, cepc_dispatch} cepc_state_t;
endpackage

// ===== src/cepc_core_event_unit.sv
// Behaviour
// [R1] nine general levels 7..15 are accepted besides the dedicated events.
// [R2] priorities are fixed with 0 highest and each priority is a vector table entry.
// [R3] the highest pending event is always dispatched before lower ones; the code keeps the level captured in idle through the save.
// [R4] a higher event may preempt an active lower service routine, so routines nest.
// [R5] an emulation event puts the core into emulation mode under the test port.
// [R6] a reset event resets the core and ranks just below emulation.
// [R7] the non-maskable event comes from watchdog expiry or the external pin.
// [R8] exceptions are taken before the faulting instruction completes.
// [R9] an alignment fault or undefined opcode raises an exception.
// [R10] interrupts come asynchronously from pins, timers, peripherals and a raise instruction.
// [R11] each event has its own return address register and return instruction.
// [R12] state is saved on the supervisor stack before the routine proceeds.
// [R13] peripheral interrupts pass the router and land on the general levels.
// [R14] software should keep levels 14 and 15 for software handlers.
// [R15] the router has a default map that software can rewrite.
// [R16] events latch pending and the best unmasked one above the active level dispatches.
module cepc_core_event_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // dedicated sources
  input wire logic emulation_event,
  input wire logic reset_event,
  input wire logic nmi_pin,
  input wire logic watchdog_expired,
  input wire logic align_fault,
  input wire logic undef_opcode,
  input wire logic hardware_error_event,
  input wire logic core_timer_event,
  // general sources
  input wire logic [31:0] periph_irq,
  input wire logic [8:0] ext_level_irq,
  input wire logic raise_valid,
  input wire logic [3:0] raise_level,
  // router assignment writes
  input wire logic assign_we,
  input wire logic [4:0] assign_idx,
  input wire logic [3:0] assign_code,
  // mask of levels, 1 enables
  input wire logic [15:0] level_enable,
  // sequencer side
  input wire logic [31:0] current_pc,
  input wire logic state_saved,
  input wire logic return_valid,
  input wire logic [3:0] return_level,
  output logic dispatch_valid,
  output logic [3:0] dispatch_vector,
  output logic save_request,
  output logic hold_commit,
  output logic emulation_mode,
  output logic core_reset,
  output logic [31:0] return_pc,
  output logic [15:0] active_levels,
  output logic [15:0] pending_levels
);
  logic [2:0] nmi_sync;
  logic nmi_level;
  logic nmi_prev;
  logic [8:0] routed;
  logic [15:0] sources;
  logic [15:0] eligible;
  logic [3:0] best;
  logic found;
  logic [3:0] active_top;
  logic any_active;
  logic [3:0] taken;
  logic [31:0] ret_regs [16];
  cepc_pkg::cepc_state_t state;

  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b0, 4'(i)};
      end
    end
    return r;
  endfunction

  // [R13] router in front of levels
  cepc_router u_router (
    .mclk(mclk),
    .reset_n(reset_n),
    .periph_irq(periph_irq),
    .assign_we(assign_we),
    .assign_idx(assign_idx),
    .assign_code(assign_code),
    .general_level_req(routed)
  );

  // pin passes three flops, agreement of last two
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_sync <= 3'h0;
      nmi_level <= 1'b0;
      nmi_prev <= 1'b0;
    end else begin
      nmi_sync <= {nmi_sync[1:0], nmi_pin};
      if (nmi_sync[2] == nmi_sync[1]) begin
        nmi_level <= nmi_sync[2];
      end
      nmi_prev <= nmi_level;
    end
  end

  always_comb begin
    sources = 16'h0000;
    // [R5] emulation request
    sources[cepc_pkg::PRIO_EMU] = emulation_event;
    // [R6] reset request
    sources[cepc_pkg::PRIO_RESET] = reset_event;
    // [R7] watchdog or pin edge
    sources[cepc_pkg::PRIO_NMI] = watchdog_expired | (nmi_level & ~nmi_prev);
    // [R9] fault kinds raise exception
    sources[cepc_pkg::PRIO_EXC] = align_fault | undef_opcode;
    sources[cepc_pkg::PRIO_HWERR] = hardware_error_event;
    sources[cepc_pkg::PRIO_TIMER] = core_timer_event;
    // [R1] nine general levels
    // [R10] pins, peripherals, raise
    sources[15:7] = routed | ext_level_irq;
    if (raise_valid && raise_level >= cepc_pkg::PRIO_GEN_FIRST) begin
      sources[raise_level] = 1'b1;
    end
    sources[cepc_pkg::PRIO_RSVD] = 1'b0;
  end

  // active level is lowest-numbered active bit
  always_comb begin
    active_top = 4'(first_set(active_levels));
    any_active = |active_levels;
  end

  // [R16] eligible pending beats active
  // [R4] nesting by strict outranking
  always_comb begin
    eligible = pending_levels & (level_enable | cepc_pkg::UNMASKABLE);
    for (int i = 0; i < 16; i++) begin
      if (any_active && 4'(i) >= active_top) begin
        eligible[i] = 1'b0;
      end
    end
    // [R3] lowest number wins
    // [R2] fixed rank
    best = 4'(first_set(eligible));
    found = |eligible;
  end

  // [R16] latch pending, set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pending_levels <= cepc_pkg::PEND_RESET;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (sources[i]) begin
          pending_levels[i] <= 1'b1;
        end else if (state == cepc_pkg::cepc_dispatch && taken == 4'(i)) begin
          pending_levels[i] <= 1'b0;
        end
      end
    end
  end

  // dispatch sequence: capture, save, dispatch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= cepc_pkg::cepc_idle;
      taken <= 4'h0;
    end else begin
      case (state)
        cepc_pkg::cepc_idle: begin
          if (found) begin
            taken <= best;
            state <= cepc_pkg::cepc_save;
          end
        end
        // [R12] wait for stack save
        cepc_pkg::cepc_save: begin
          if (state_saved) begin
            state <= cepc_pkg::cepc_dispatch;
          end
        end
        cepc_pkg::cepc_dispatch: begin
          state <= cepc_pkg::cepc_idle;
        end
        default: begin
          state <= cepc_pkg::cepc_idle;
        end
      endcase
    end
  end

  // [R12] save request while saving
  assign save_request = (state == cepc_pkg::cepc_save);
  // [R8] hold faulting instruction
  assign hold_commit = pending_levels[cepc_pkg::PRIO_EXC] | sources[cepc_pkg::PRIO_EXC];

  // active set: set on dispatch, cleared by return
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      active_levels <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (state == cepc_pkg::cepc_dispatch && taken == 4'(i)) begin
          active_levels[i] <= 1'b1;
        end else if (return_valid && return_level == 4'(i)) begin
          active_levels[i] <= 1'b0;
        end
      end
    end
  end

  // [R11] per-event return address
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) begin
        ret_regs[i] <= cepc_pkg::RETADDR_RESET;
      end
    end else if (state == cepc_pkg::cepc_dispatch) begin
      ret_regs[taken] <= current_pc;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dispatch_valid <= 1'b0;
      dispatch_vector <= 4'h0;
      return_pc <= cepc_pkg::RETADDR_RESET;
      emulation_mode <= 1'b0;
      core_reset <= 1'b0;
    end else begin
      // [R2] vector entry equals priority
      dispatch_valid <= (state == cepc_pkg::cepc_dispatch);
      if (state == cepc_pkg::cepc_dispatch) begin
        dispatch_vector <= taken;
      end
      // [R11] return resumes from own register
      if (return_valid) begin
        return_pc <= ret_regs[return_level];
      end
      // [R5] emulation mode held until return
      if (state == cepc_pkg::cepc_dispatch && taken == cepc_pkg::PRIO_EMU) begin
        emulation_mode <= 1'b1;
      end else if (return_valid && return_level == cepc_pkg::PRIO_EMU) begin
        emulation_mode <= 1'b0;
      end
      // [R6] one-cycle core reset pulse
      core_reset <= (state == cepc_pkg::cepc_dispatch && taken == cepc_pkg::PRIO_RESET);
    end
  end
endmodule // cepc_core_event_unit

// ===== src/cepc_router.sv
module cepc_router (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // peripheral requests, already in mclk domain
  input wire logic [31:0] periph_irq,
  // assignment write port
  input wire logic assign_we,
  input wire logic [4:0] assign_idx,
  input wire logic [3:0] assign_code,
  // levels 7..15 out
  output logic [8:0] general_level_req
);
  logic [3:0] route_map [32];

  // [R15] default map, writable
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        route_map[i] <= cepc_pkg::ROUTE_DEFAULT[i*4 +: 4];
      end
    end else if (assign_we) begin
      route_map[assign_idx] <= assign_code;
    end
  end

  // [R13] peripherals reach general levels
  always_comb begin
    general_level_req = 9'h000;
    for (int i = 0; i < 32; i++) begin
      if (periph_irq[i] && route_map[i] < 4'h9) begin
        general_level_req[route_map[i]] = 1'b1;
      end
    end
  end
endmodule // cepc_router

// ===== tb/cepc_core_event_unit_asserts.sv
module cepc_core_event_unit_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // watched
  input wire logic align_fault,
  input wire logic core_timer_event,
  input wire logic [8:0] ext_level_irq,
  input wire logic state_saved,
  input wire logic dispatch_valid,
  input wire logic [3:0] dispatch_vector,
  input wire logic save_request,
  input wire logic hold_commit,
  input wire logic emulation_mode,
  input wire logic core_reset,
  input wire logic [15:0] active_levels,
  input wire logic [15:0] pending_levels
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_saved;
    save_request && state_saved;
  endsequence
  sequence s_disp;
    dispatch_valid;
  endsequence
  save_dispatch_a: assert property (s_saved |-> ##2 dispatch_valid)
    else $error("no dispatch after save");
  disp_pulse_a: assert property (s_disp |=> !dispatch_valid)
    else $error("dispatch pulse too long");
  disp_active_a: assert property (s_disp |-> active_levels[dispatch_vector])
    else $error("dispatched level not active");
  no_level4_a: assert property (!pending_levels[4])
    else $error("reserved level pending");
  hold_exc_a: assert property (align_fault |-> hold_commit)
    else $error("commit not held on fault");
  timer_pend_a: assert property (core_timer_event |=> pending_levels[6])
    else $error("timer not pending");
  ext_pend_a: assert property (ext_level_irq[0] |=> pending_levels[7])
    else $error("level 7 not pending");
  emu_mode_a: assert property (s_disp ##0 (dispatch_vector == 4'h0) |-> ##[0:1] emulation_mode)
    else $error("emulation mode missing");
  reset_pulse_a: assert property (core_reset |=> !core_reset)
    else $error("core reset too long");
endmodule // cepc_core_event_unit_asserts

bind cepc_core_event_unit cepc_core_event_unit_asserts u_chk (.mclk(mclk), .reset_n(reset_n),
  .align_fault(align_fault), .core_timer_event(core_timer_event), .ext_level_irq(ext_level_irq),
  .state_saved(state_saved), .dispatch_valid(dispatch_valid), .dispatch_vector(dispatch_vector),
  .save_request(save_request), .hold_commit(hold_commit), .emulation_mode(emulation_mode),
  .core_reset(core_reset), .active_levels(active_levels), .pending_levels(pending_levels));

// ===== tb/cepc_seq_model.sv
module cepc_seq_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // save handshake
  input wire logic save_request,
  input wire logic slow,
  output logic state_saved
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_saved <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (save_request && !state_saved) begin
      if (!slow || wait_cnt == 2'h2) begin
        state_saved <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end else begin
      state_saved <= 1'b0;
      wait_cnt <= 2'h0;
    end
  end
endmodule // cepc_seq_model

// ===== tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
  logic mclk = 0, reset_n = 0, hwe = 0, tmr = 0, rv = 0, awe = 0, ret = 0, slow = 0;
  logic auto_ret = 1, dval, sreq, ssav;
  logic [5:0] ded = 0;
  logic [31:0] pirq = 0, pc = 0, rpc, lf = 32'h034d, p12, p9;
  logic [8:0] ext = 0;
  logic [3:0] rl = 0, acode = 0, retl = 0, dv, ev;
  logic [4:0] aidx = 0;
  logic [15:0] en = 16'hffff, act, pend;
  logic [3:0] q[$];
  logic [3:0] dexp[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h3, 4'h2};
  int n_mismatch = 0, total_checks = 0;
  cepc_core_event_unit dut (.mclk(mclk), .reset_n(reset_n), .emulation_event(ded[0]),
    .reset_event(ded[1]), .watchdog_expired(ded[2]), .align_fault(ded[3]),
    .undef_opcode(ded[4]), .nmi_pin(ded[5]), .hardware_error_event(hwe),
    .core_timer_event(tmr), .periph_irq(pirq), .ext_level_irq(ext), .raise_valid(rv),
    .raise_level(rl), .assign_we(awe), .assign_idx(aidx), .assign_code(acode),
    .level_enable(en), .current_pc(pc), .state_saved(ssav), .return_valid(ret),
    .return_level(retl), .dispatch_valid(dval), .dispatch_vector(dv), .save_request(sreq),
    .hold_commit(), .emulation_mode(), .core_reset(), .return_pc(rpc),
    .active_levels(act), .pending_levels(pend));
  cepc_seq_model m (.mclk(mclk), .reset_n(reset_n), .save_request(sreq), .slow(slow),
    .state_saved(ssav));
  initial forever #50 mclk = ~mclk;
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [3:0] dmap(input logic [4:0] i);
    return (i < 14) ? 4'h7 : (i < 16) ? 4'h8 : (i < 20) ? 4'h9 : (i < 26) ? 4'ha : 4'hb;
  endfunction
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task raise(input logic [3:0] l);
    @(posedge mclk) begin rv <= 1; rl <= l; end
    @(posedge mclk) rv <= 0;
  endtask
  task ret_lvl(input logic [3:0] l);
    @(posedge mclk) begin ret <= 1; retl <= l; end
    @(posedge mclk) ret <= 0;
  endtask
  task periph(input logic [4:0] i);
    @(posedge mclk) pirq <= 32'h1 << i;
    @(posedge mclk) pirq <= 0;
  endtask
  task settle(input string s);
    for (int k = 0; k < 300 && q.size() != 0; k++) tick(1);
    tick(8);
    `CHK(q.size(), 0)
    $display("test %s done", s);
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) if (auto_ret) begin
    ret <= (dval === 1'b1);
    retl <= dv;
  end
  always @(posedge mclk) if (dval === 1'b1) begin
    if (q.size() == 0) `CHK(dv, 4'hx)
    else begin
      // pop once, the macro reads its arguments twice
      ev = q.pop_front();
      `CHK(dv, ev)
    end
  end
  initial begin
    #500000;
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1;
    q = '{4'h5, 4'h6, 4'h7, 4'hf};
    @(posedge mclk) begin hwe <= 1; tmr <= 1; ext <= 9'h001; rv <= 1; rl <= 4'hf; end
    @(posedge mclk) begin hwe <= 0; tmr <= 0; ext <= 0; rv <= 0; end
    settle("priority");
    slow <= 1;
    for (int i = 0; i < 6; i++) begin
      q.push_back(dexp[i]);
      @(posedge mclk) ded[i] <= 1;
      // pin filter drops single-cycle pulses
      if (i == 5) tick(2);
      @(posedge mclk) ded[i] <= 0;
      settle("dedicated");
    end
    slow <= 0;
    auto_ret <= 0;
    p12 = lf;
    pc <= p12;
    q.push_back(4'hc);
    raise(4'hc);
    settle("base");
    lf = nxt(lf);
    p9 = lf;
    pc <= p9;
    q.push_back(4'h9);
    raise(4'h9);
    settle("nest");
    `CHK(act, 16'h1200)
    raise(4'hd);
    tick(6);
    `CHK(pend[13], 1'b1)
    ret_lvl(4'h9);
    tick(2);
    `CHK(rpc, p9)
    q.push_back(4'hd);
    ret_lvl(4'hc);
    tick(2);
    `CHK(rpc, p12)
    settle("return");
    ret_lvl(4'hd);
    auto_ret <= 1;
    en <= 16'hfbff;
    raise(4'ha);
    tick(6);
    `CHK(pend[10], 1'b1)
    q.push_back(4'ha);
    en <= 16'hffff;
    settle("mask");
    raise(4'h4);
    raise(4'h3);
    tick(4);
    `CHK(pend, 16'h0000)
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      q.push_back(dmap(lf[4:0]));
      periph(lf[4:0]);
      settle("route");
      @(posedge mclk) begin awe <= 1; aidx <= lf[4:0]; acode <= 4'(lf[8:5] % 9); end
      @(posedge mclk) awe <= 0;
      q.push_back(4'h7 + 4'(lf[8:5] % 9));
      periph(lf[4:0]);
      settle("remap");
      // restore default so a repeated index keeps its expectation
      @(posedge mclk) begin awe <= 1; acode <= dmap(lf[4:0]) - 4'h7; end
      @(posedge mclk) awe <= 0;
    end
    @(posedge mclk) begin awe <= 1; acode <= 4'h9; end
    @(posedge mclk) awe <= 0;
    periph(aidx);
    tick(6);
    `CHK(pend, 16'h0000)
    final_report;
  end
endmodule // tb
